// ===== src/interrupt_status_flags_regs.vh
// Register address, field positions and timing constants of the status flag block
`ifndef INTERRUPT_STATUS_FLAGS_REGS_VH
`define INTERRUPT_STATUS_FLAGS_REGS_VH

// ============================================================
// Register map
`define STATUS_WORD_ADDR 7'h01
`define STATUS_WORD_W 24

// ============================================================
// Field positions in the status word
`define FAST_RECOVERY_BIT 21
`define DC_LEAD_OFF_BIT 20
`define LEADS_ON_BIT 11
`define BEAT_EVENT_BIT 10
`define SYNC_TICK_BIT 9
`define PLL_UNLOCK_BIT 8
`define POS_INPUT_HIGH_BIT 3
`define POS_INPUT_LOW_BIT 2
`define NEG_INPUT_HIGH_BIT 1
`define NEG_INPUT_LOW_BIT 0

// ============================================================
// Management field encodings and reset values
`define BEAT_CLR_ON_STATUS 2'h0
`define BEAT_CLR_ON_BEAT_READ 2'h1
`define BEAT_CLR_SELF 2'h2
`define LEADS_ON_MODE_A 2'h1
`define LEADS_ON_MODE_B 2'h2
`define TICK_DIV_1 2'h0
`define TICK_DIV_2 2'h1
`define TICK_DIV_4 2'h2
`define TICK_DIV_16 2'h3
`define TICK_CLEAR_MODE_RST 1'h1
`define FAST_CLEAR_MODE_RST 1'h0

// ============================================================
// Timing
`define CLK_FREQ_KHZ 200000
`define LEAD_OFF_TIME_MS 115
`define LEAD_OFF_CYCLES (`LEAD_OFF_TIME_MS * `CLK_FREQ_KHZ)

`endif

// ===== src/hold_timer.v
// Reloadable down counter that reports when a run has lasted its load value
`timescale 1ns/1ps

module hold_timer #(
    parameter W = 25
) (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire run_i,
    input wire [W-1:0] load_val_i,
    output reg expired_o
);

    reg [W-1:0] cnt_q;

    // ============================================================
    // Counter
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= {W{1'b0}};
            expired_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q <= load_val_i;
            expired_o <= 1'b0;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end else begin
            expired_o <= 1'b1;
        end
    end

endmodule

// ===== src/interrupt_status_flags.v
// Status word and sticky interrupt flag logic of the heart-signal front end
// Behaviour
// - Read-only 24-bit status word at 0x01
// - Upper bytes show flags regardless of masks
// - All interrupt terms are active high
// - Fast recovery flag rises on mode entry
// - Lead-off flag after 115ms, held till read
// - Read clear happens at 32nd serial edge
// - Leads-on flag set when mode enabled
// - Host reads once; read clears, arms detection
// - Armed leads-on flag follows condition, held
// - Beat flag per new R event
// - Tick flag on sampling instant, divided
// - PLL unlock flag only with channel enabled
// - Detail lead-off bits occupy bits 3..0
// - Detail bits set with lead-off flag, held
// - Read does not clear persisting lead-off
// - Low byte detail, upper bytes terms
// - Fast flag clear mode selects hold style
// - Beat clear mode: status, beat read, self
// - Tick clear mode: status read or self
// - Tick divider 1, 2, 4 or 16
`timescale 1ns/1ps
`include "interrupt_status_flags_regs.vh"

module interrupt_status_flags #(
    parameter LEAD_OFF_CYCLES = `LEAD_OFF_CYCLES,
    parameter LO_W = 25,
    parameter PERIOD_W = 24
) (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire [6:0] rd_addr_i,
    input wire rd_done_i,
    input wire beat_reg_read_done_i,
    input wire fast_flag_clear_mode_i,
    input wire [1:0] beat_flag_clear_mode_i,
    input wire tick_clear_mode_i,
    input wire [1:0] tick_divider_i,
    input wire [1:0] low_power_leads_on_enable_i,
    input wire fast_mode_i,
    input wire lead_off_detect_enable_i,
    input wire [3:0] lead_off_cond_i,
    input wire leads_on_cond_i,
    input wire beat_detect_i,
    input wire sample_instant_i,
    input wire pll_unlock_i,
    input wire channel_enable_i,
    output reg [23:0] rd_data_o,
    output reg leads_on_armed_o
);

    // ============================================================
    // Read decode
    // The serial engine pulses rd_done_i at the 32nd serial clock edge of a read,
    // so clearing never happens before the host has shifted out the whole word.
    wire status_rd = rd_done_i && (rd_addr_i == `STATUS_WORD_ADDR);

    reg fast_flag_q;
    reg dc_flag_q;
    reg lon_flag_q;
    reg beat_flag_q;
    reg tick_flag_q;
    reg pll_flag_q;
    reg [3:0] detail_q;
    reg fast_d;
    reg dc_d;
    reg lon_d;
    reg beat_d;
    reg tick_d;
    reg pll_d;
    reg [3:0] detail_d;

    // ============================================================
    // Fast recovery flag
    reg fast_mode_q;
    reg fast_served_q;
    wire fast_entry = fast_mode_i && !fast_mode_q;

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fast_mode_q <= 1'b0;
            fast_served_q <= 1'b0;
        end else begin
            fast_mode_q <= fast_mode_i;
            // Once read in mode 1 the flag waits for exit and re-entry
            if (!fast_mode_i) begin
                fast_served_q <= 1'b0;
            end else if (status_rd && fast_flag_clear_mode_i) begin
                fast_served_q <= 1'b1;
            end
        end
    end

    always @* begin
        if (!fast_flag_clear_mode_i) begin
            // Live while engaged, then sticky until read
            fast_d = fast_mode_i || (fast_flag_q && !status_rd);
        end else begin
            fast_d = (fast_entry && !fast_served_q) || (fast_flag_q && !status_rd);
        end
    end

    // ============================================================
    // DC lead-off persistence
    wire lo_active = lead_off_detect_enable_i && (lead_off_cond_i != 4'h0);
    wire lo_persist;

    // Expiry lands one edge after the count runs out, so the flag rises strictly after the interval
    hold_timer #(
        .W(LO_W)
    ) u_lead_off_timer (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .run_i(lo_active),
        .load_val_i(LEAD_OFF_CYCLES[LO_W-1:0]),
        .expired_o(lo_persist)
    );

    always @* begin
        // Live term wins over the read, so a persisting condition survives it
        dc_d = lo_persist || (dc_flag_q && !status_rd);
        detail_d = (lo_persist ? lead_off_cond_i : 4'h0) |
                   (detail_q & {4{!status_rd}});
    end

    // ============================================================
    // Leads-on flag and arming
    reg [1:0] lon_mode_q;
    wire lon_mode_on = (low_power_leads_on_enable_i == `LEADS_ON_MODE_A) ||
                       (low_power_leads_on_enable_i == `LEADS_ON_MODE_B);
    wire lon_mode_was = (lon_mode_q == `LEADS_ON_MODE_A) || (lon_mode_q == `LEADS_ON_MODE_B);
    wire lon_enabled_now = lon_mode_on && !lon_mode_was;

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lon_mode_q <= 2'h0;
            leads_on_armed_o <= 1'b0;
        end else begin
            lon_mode_q <= low_power_leads_on_enable_i;
            if (!lon_mode_on || lon_enabled_now) begin
                leads_on_armed_o <= 1'b0;
            end else if (status_rd) begin
                leads_on_armed_o <= 1'b1;
            end
        end
    end

    always @* begin
        if (lon_enabled_now) begin
            lon_d = 1'b1;
        end else if (leads_on_armed_o) begin
            lon_d = leads_on_cond_i || (lon_flag_q && !status_rd);
        end else begin
            // The one read after enabling clears the announce flag
            lon_d = lon_flag_q && !status_rd;
        end
    end

    // ============================================================
    // Data-rate period measurement
    // Self-clear times follow the measured sample spacing instead of a fixed
    // constant, so they track whatever output rate the converter runs at.
    reg [PERIOD_W-1:0] period_cnt_q;
    reg [PERIOD_W-1:0] period_q;

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            period_cnt_q <= {PERIOD_W{1'b0}};
            period_q <= {PERIOD_W{1'b0}};
        end else if (sample_instant_i) begin
            period_cnt_q <= {PERIOD_W{1'b0}};
            period_q <= period_cnt_q;
        end else if (period_cnt_q != {PERIOD_W{1'b1}}) begin
            period_cnt_q <= period_cnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
        end
    end

    // ============================================================
    // Beat event flag
    wire beat_self = (beat_flag_clear_mode_i == `BEAT_CLR_SELF);
    wire beat_expired;

    hold_timer #(
        .W(PERIOD_W)
    ) u_beat_timer (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .run_i(beat_self && beat_flag_q && !beat_detect_i),
        .load_val_i(period_q),
        .expired_o(beat_expired)
    );

    reg beat_clr;

    always @* begin
        case (beat_flag_clear_mode_i)
            `BEAT_CLR_ON_STATUS: beat_clr = status_rd;
            `BEAT_CLR_ON_BEAT_READ: beat_clr = beat_reg_read_done_i;
            `BEAT_CLR_SELF: beat_clr = beat_expired;
            // Reserved code: the flag simply stays sticky
            default: beat_clr = 1'b0;
        endcase
        beat_d = beat_detect_i || (beat_flag_q && !beat_clr);
    end

    // ============================================================
    // Sample sync tick
    reg [3:0] tick_div_q;
    reg [3:0] tick_mask;
    wire tick_issue;
    wire tick_expired;

    always @* begin
        case (tick_divider_i)
            `TICK_DIV_1: tick_mask = 4'h0;
            `TICK_DIV_2: tick_mask = 4'h1;
            `TICK_DIV_4: tick_mask = 4'h3;
            `TICK_DIV_16: tick_mask = 4'hf;
            default: tick_mask = 4'h0;
        endcase
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_div_q <= 4'h0;
        end else if (sample_instant_i) begin
            tick_div_q <= tick_div_q + 4'h1;
        end
    end

    assign tick_issue = sample_instant_i && ((tick_div_q & tick_mask) == 4'h0);

    hold_timer #(
        .W(PERIOD_W)
    ) u_tick_timer (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .run_i(tick_clear_mode_i && tick_flag_q && !tick_issue),
        .load_val_i({2'h0, period_q[PERIOD_W-1:2]}),
        .expired_o(tick_expired)
    );

    always @* begin
        if (tick_clear_mode_i) begin
            tick_d = tick_issue || (tick_flag_q && !tick_expired);
        end else begin
            tick_d = tick_issue || (tick_flag_q && !status_rd);
        end
    end

    // ============================================================
    // PLL unlock flag
    always @* begin
        pll_d = (pll_unlock_i && channel_enable_i) || (pll_flag_q && !status_rd);
    end

    // ============================================================
    // Flag registers
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fast_flag_q <= 1'b0;
            dc_flag_q <= 1'b0;
            lon_flag_q <= 1'b0;
            beat_flag_q <= 1'b0;
            tick_flag_q <= 1'b0;
            pll_flag_q <= 1'b0;
            detail_q <= 4'h0;
        end else begin
            fast_flag_q <= fast_d;
            dc_flag_q <= dc_d;
            lon_flag_q <= lon_d;
            beat_flag_q <= beat_d;
            tick_flag_q <= tick_d;
            pll_flag_q <= pll_d;
            detail_q <= detail_d;
        end
    end

    // ============================================================
    // Status word readback
    // Assembled from the next-state values so the host sees exactly what the
    // flags hold; no write path exists, so software cannot disturb the word.
    reg [23:0] word_d;

    always @* begin
        word_d = 24'h000000;
        word_d[`FAST_RECOVERY_BIT] = fast_d;
        word_d[`DC_LEAD_OFF_BIT] = dc_d;
        word_d[`LEADS_ON_BIT] = lon_d;
        word_d[`BEAT_EVENT_BIT] = beat_d;
        word_d[`SYNC_TICK_BIT] = tick_d;
        word_d[`PLL_UNLOCK_BIT] = pll_d;
        word_d[`POS_INPUT_HIGH_BIT:`NEG_INPUT_LOW_BIT] = detail_d;
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= 24'h000000;
        end else begin
            rd_data_o <= word_d;
        end
    end

endmodule

// ===== tb/spi_host_model.sv
// Host model that issues serial register reads ending on the 32nd serial edge
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic [6:0] addr_i,
    output logic [6:0] rd_addr_o,
    output logic rd_done_o
);
    logic [5:0] edge_cnt_q;
    // ============================================================
    // Frame: one serial edge per clock keeps runs short
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            edge_cnt_q <= 6'h0;
            rd_done_o <= 1'b0;
            rd_addr_o <= 7'h7f;
        end else begin
            rd_done_o <= edge_cnt_q == 6'h1f;
            if (start_i) begin
                edge_cnt_q <= 6'h1;
                rd_addr_o <= addr_i;
            end else if (edge_cnt_q == 6'h20) begin
                edge_cnt_q <= 6'h0;
                // Stale address is not kept once the frame is over
                rd_addr_o <= ~rd_addr_o;
            end else if (edge_cnt_q != 6'h0) begin
                edge_cnt_q <= edge_cnt_q + 6'h1;
            end
        end
    end
endmodule

// ===== tb/interrupt_status_flags_checker.sv
// Port-level assertions for the status flag block
`timescale 1ns/1ps
module interrupt_status_flags_checker #(
    parameter LEAD_OFF_CYCLES = 20
) (
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire [6:0] rd_addr_i,
    input wire rd_done_i,
    input wire beat_reg_read_done_i,
    input wire fast_flag_clear_mode_i,
    input wire [1:0] beat_flag_clear_mode_i,
    input wire tick_clear_mode_i,
    input wire [1:0] tick_divider_i,
    input wire [1:0] low_power_leads_on_enable_i,
    input wire fast_mode_i,
    input wire lead_off_detect_enable_i,
    input wire [3:0] lead_off_cond_i,
    input wire leads_on_cond_i,
    input wire beat_detect_i,
    input wire sample_instant_i,
    input wire pll_unlock_i,
    input wire channel_enable_i,
    input wire [23:0] rd_data_o,
    input wire leads_on_armed_o
);
    int lo_cnt_q;
    wire rd_st = rd_done_i && rd_addr_i == 7'h01;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // ============================================================
    // Lead-off run length, restarted whenever the condition drops
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) lo_cnt_q <= 0;
        else lo_cnt_q <= (lead_off_detect_enable_i && lead_off_cond_i != 4'h0) ? lo_cnt_q + 1 : 0;
    end
    // ============================================================
    // Assertions
    property p_unused_zero;
        {rd_data_o[23:22], rd_data_o[19:12], rd_data_o[7:4]} == 14'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");
    property p_beat_set;
        beat_detect_i |=> rd_data_o[10];
    endproperty
    a_beat_set: assert property (p_beat_set) else $error("beat flag missing");
    property p_tick_set;
        sample_instant_i && tick_divider_i == 2'h0 |=> rd_data_o[9];
    endproperty
    a_tick_set: assert property (p_tick_set) else $error("tick flag missing");
    property p_pll_cause;
        $rose(rd_data_o[8]) |-> $past(pll_unlock_i && channel_enable_i);
    endproperty
    a_pll_cause: assert property (p_pll_cause) else $error("pll flag without cause");
    property p_pll_hold;
        rd_data_o[8] && !rd_st |=> rd_data_o[8];
    endproperty
    a_pll_hold: assert property (p_pll_hold) else $error("pll flag lost");
    property p_fast_set;
        fast_mode_i && !fast_flag_clear_mode_i |=> rd_data_o[21];
    endproperty
    a_fast_set: assert property (p_fast_set) else $error("fast flag missing");
    property p_fast_no_reassert;
        fast_flag_clear_mode_i && !rd_data_o[21] && fast_mode_i && $past(fast_mode_i)
            && $past(arst_n_i) |=> !rd_data_o[21];
    endproperty
    a_fast_no_reassert: assert property (p_fast_no_reassert) else $error("fast re-set");
    property p_beat_clear;
        rd_st && beat_flag_clear_mode_i == 2'h0 && !beat_detect_i |=> !rd_data_o[10];
    endproperty
    a_beat_clear: assert property (p_beat_clear) else $error("beat flag not cleared");
    property p_dc_time;
        $rose(rd_data_o[20]) |-> lo_cnt_q >= LEAD_OFF_CYCLES && rd_data_o[3:0] != 4'h0;
    endproperty
    a_dc_time: assert property (p_dc_time) else $error("lead-off flag early");
    property p_leads_on_arm;
        rd_st && rd_data_o[11] && !leads_on_armed_o && !leads_on_cond_i
            && (low_power_leads_on_enable_i == 2'h1 || low_power_leads_on_enable_i == 2'h2)
            && $stable(low_power_leads_on_enable_i)
            |=> leads_on_armed_o && !rd_data_o[11];
    endproperty
    a_leads_on_arm: assert property (p_leads_on_arm) else $error("leads-on not armed");
    property p_leads_on_follow;
        leads_on_armed_o && leads_on_cond_i |=> rd_data_o[11];
    endproperty
    a_leads_on_follow: assert property (p_leads_on_follow) else $error("leads-on lost");
endmodule
bind interrupt_status_flags interrupt_status_flags_checker #(
    .LEAD_OFF_CYCLES(LEAD_OFF_CYCLES)
) u_interrupt_status_flags_checker (.*);

// ===== tb/interrupt_status_flags_test.sv
// Self-checking bench for the status flag block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    total_checks++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end
module interrupt_status_flags_test;
    localparam int LO_CYC = 20;
    logic clk_sys_i, arst_n_i, rd_done_i, beat_reg_read_done_i, fast_flag_clear_mode_i;
    logic tick_clear_mode_i, fast_mode_i, lead_off_detect_enable_i, leads_on_cond_i;
    logic beat_detect_i, sample_instant_i, pll_unlock_i, channel_enable_i, leads_on_armed_o;
    logic [1:0] beat_flag_clear_mode_i, tick_divider_i, low_power_leads_on_enable_i;
    logic [3:0] lead_off_cond_i;
    logic [6:0] rd_addr_i, host_addr;
    logic [23:0] rd_data_o;
    logic host_start;
    logic [4:0] tick_seen;
    int failures = 0;
    int total_checks = 0;
    typedef struct {logic [3:0] ev; logic [23:0] exp;} row_t;
    row_t rows[4] = '{'{4'h8, 24'h200000}, '{4'h4, 24'h000400}, '{4'h2, 24'h000200},
        '{4'h1, 24'h000100}};
    interrupt_status_flags #(.LEAD_OFF_CYCLES(LO_CYC)) u_interrupt_status_flags (.*);
    spi_host_model u_spi_host_model (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .start_i(host_start), .addr_i(host_addr), .rd_addr_o(rd_addr_i), .rd_done_o(rd_done_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // Read completes on edge 32; the flag update lands one edge later
    task automatic rd(input logic [6:0] a);
        host_addr = a;
        host_start = 1'b1;
        step(1);
        host_start = 1'b0;
        step(33);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        failures++;
        final_report;
    end
    initial begin
        {beat_reg_read_done_i, fast_flag_clear_mode_i, tick_clear_mode_i, fast_mode_i} = 4'h0;
        {lead_off_detect_enable_i, leads_on_cond_i, beat_detect_i, sample_instant_i} = 4'h0;
        {pll_unlock_i, channel_enable_i, host_start, arst_n_i} = 4'h0;
        {beat_flag_clear_mode_i, tick_divider_i, low_power_leads_on_enable_i} = 6'h0;
        lead_off_cond_i = 4'h0;
        host_addr = 7'h01;
        step(3);
        `CHK("reset", 24'h0, rd_data_o)
        arst_n_i = 1'b1;
        step(2);
        done("startup");
        foreach (rows[i]) begin
            {fast_mode_i, beat_detect_i, sample_instant_i, pll_unlock_i} = rows[i].ev;
            channel_enable_i = rows[i].ev[0];
            step(1);
            {fast_mode_i, beat_detect_i, sample_instant_i, pll_unlock_i} = 4'h0;
            step(2);
            `CHK("set", rows[i].exp, rd_data_o)
            rd(7'h02);
            `CHK("other read", rows[i].exp, rd_data_o)
            rd(7'h01);
            `CHK("clear", 24'h0, rd_data_o)
        end
        done("rows");
        channel_enable_i = 1'b0;
        pll_unlock_i = 1'b1;
        step(3);
        `CHK("pll gated", 1'b0, rd_data_o[8])
        channel_enable_i = 1'b1;
        step(2);
        rd(7'h01);
        `CHK("pll persist", 1'b1, rd_data_o[8])
        pll_unlock_i = 1'b0;
        rd(7'h01);
        `CHK("pll clear", 1'b0, rd_data_o[8])
        done("pll");
        lead_off_detect_enable_i = 1'b1;
        lead_off_cond_i = 4'ha;
        step(LO_CYC / 2);
        `CHK("lead off early", 24'h0, rd_data_o)
        step(LO_CYC);
        `CHK("lead off", 24'h10000a, rd_data_o)
        rd(7'h01);
        `CHK("lead off persist", 24'h10000a, rd_data_o)
        lead_off_cond_i = 4'h0;
        step(2);
        `CHK("lead off held", 24'h10000a, rd_data_o)
        rd(7'h01);
        `CHK("lead off clear", 24'h0, rd_data_o)
        done("lead off");
        for (int m = 1; m < 3; m++) begin
            low_power_leads_on_enable_i = 2'h0;
            step(1);
            low_power_leads_on_enable_i = m[1:0];
            step(2);
            `CHK("leads on set", 1'b1, rd_data_o[11])
            rd(7'h01);
            `CHK("armed", 2'h1, {rd_data_o[11], leads_on_armed_o})
            leads_on_cond_i = 1'b1;
            step(2);
            leads_on_cond_i = 1'b0;
            step(2);
            `CHK("leads on held", 1'b1, rd_data_o[11])
            rd(7'h01);
            `CHK("leads on clear", 1'b0, rd_data_o[11])
        end
        done("leads on");
        fast_mode_i = 1'b1;
        step(2);
        rd(7'h01);
        `CHK("fast engaged", 1'b1, rd_data_o[21])
        fast_flag_clear_mode_i = 1'b1;
        rd(7'h01);
        `CHK("fast cleared", 1'b0, rd_data_o[21])
        fast_mode_i = 1'b0;
        step(1);
        fast_mode_i = 1'b1;
        step(2);
        `CHK("fast reentry", 1'b1, rd_data_o[21])
        fast_mode_i = 1'b0;
        rd(7'h01);
        done("fast");
        beat_flag_clear_mode_i = 2'h1;
        beat_detect_i = 1'b1;
        step(1);
        beat_detect_i = 1'b0;
        rd(7'h01);
        `CHK("beat kept", 1'b1, rd_data_o[10])
        beat_reg_read_done_i = 1'b1;
        step(1);
        beat_reg_read_done_i = 1'b0;
        step(1);
        `CHK("beat read clear", 1'b0, rd_data_o[10])
        {beat_flag_clear_mode_i, tick_clear_mode_i} = 3'h5;
        // Two instants 16 cycles apart give the data-rate period
        repeat (2) begin
            sample_instant_i = 1'b1;
            step(1);
            sample_instant_i = 1'b0;
            step(15);
        end
        {beat_detect_i, sample_instant_i} = 2'h3;
        step(1);
        {beat_detect_i, sample_instant_i} = 2'h0;
        `CHK("self set", 2'h3, rd_data_o[10:9])
        step(8);
        `CHK("tick self clear", 2'h2, rd_data_o[10:9])
        step(12);
        `CHK("self clear", 2'h0, rd_data_o[10:9])
        done("clear modes");
        // Tick watched on its own, as on a dedicated line
        for (int d = 1; d < 4; d++) begin
            tick_divider_i = d[1:0];
            tick_seen = 5'h00;
            repeat (16) begin
                sample_instant_i = 1'b1;
                step(1);
                sample_instant_i = 1'b0;
                tick_seen = tick_seen + {4'h0, rd_data_o[9]};
                step(15);
            end
            `CHK("tick divide", 5'(16 / (d == 3 ? 16 : 2 * d)), tick_seen)
        end
        done("tick divide");
        pll_unlock_i = 1'b1;
        step(2);
        `CHK("pre reset", 1'b1, rd_data_o[8])
        arst_n_i = 1'b0;
        #1;
        `CHK("async reset", 25'h0, {rd_data_o, leads_on_armed_o})
        pll_unlock_i = 1'b0;
        low_power_leads_on_enable_i = 2'h0;
        step(3);
        arst_n_i = 1'b1;
        step(2);
        `CHK("after reset", 24'h0, rd_data_o)
        done("reset");
        final_report;
    end
endmodule
